// ===== mfp_map_pkg.sv
// Constants, field layouts and carrier types for the middle-range multifunction pin decoder
package mfp_map_pkg;
	localparam int NUM_PINS = 7;
	localparam int NUM_REFS = 4;
	localparam int NUM_CTRL = 11;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] ADDR_FUNC_BASE = 8'h00;
	localparam logic [7:0] ADDR_BOOL_LO = 8'h08;
	localparam logic [7:0] ADDR_BOOL_HI = 8'h09;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h11;
	localparam logic [7:0] ADDR_PIN_LEVEL = 8'h12;
	localparam logic [7:0] ADDR_CTRL_STATE = 8'h13;
	localparam int BOOL_LO_PINS = 4;

	// Reset values
	localparam logic [7:0] FUNC_RESET = 8'h00;
	localparam logic [1:0] BOOL_RESET = 2'h0;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

	// Boolean code fields
	localparam int BOOL_INV_BIT = 0;
	localparam int BOOL_OR_BIT = 1;

	// Interrupt event bit positions
	localparam int EV_IRQ_CLEAR = 0;
	localparam int EV_FAULT_FORCE = 1;
	localparam int EV_VALID_TIMEOUT = 2;
	localparam int EV_CODE_REJECT = 3;
	localparam int NUM_EV = 4;

	// Function codes
	localparam logic [6:0] CODE_RANGE_LO = 7'h11;
	localparam logic [6:0] CODE_RANGE_HI = 7'h37;
	localparam logic [6:0] CODE_CLR_COMMON = 7'h11;
	localparam logic [6:0] CODE_CLR_CH0 = 7'h12;
	localparam logic [6:0] CODE_CLR_CH1 = 7'h13;
	localparam logic [6:0] CODE_DIV_RESYNC = 7'h1C;
	localparam logic [6:0] CODE_REF_FAULT = 7'h20;
	localparam logic [6:0] CODE_REF_VALID = 7'h24;
	localparam logic [6:0] CODE_REF_ACTIVE = 7'h28;
	localparam logic [6:0] CODE_LOOP_LOCK = 7'h30;
	localparam logic [6:0] CODE_LOOP_ACTIVE = 7'h34;
	localparam logic [6:0] CODE_LOOP_STATE = 7'h35;
	localparam logic [6:0] CODE_UNUSED_2C = 7'h2C;

	// Source flag positions
	localparam int DIV_RESYNC_LO_BIT = 3;
	localparam int DIV_RESYNC_HI_BIT = 7;
	localparam int REF_FAULT_BIT = 3;
	localparam int REF_VALID_BIT = 4;
	localparam int LOOP_LOCK_FIRST_BIT = 1;
	localparam int LOOP_ACTIVE_TOP_BIT = 5;
	localparam int LOOP_STATE_FIRST_BIT = 0;

	typedef struct packed {
		logic outEn;
		logic [6:0] code;
	} pinFunc_t;

	typedef struct packed {
		logic [7:0] commonIrq;
		logic [7:0] ch0Irq;
		logic [7:0] ch1Irq;
		logic [7:0] divResyncB;
		logic [7:0] divResyncA;
		logic [NUM_REFS-1:0][7:0] refStat;
		logic [7:0] loopActive;
		logic [7:0] loopLock;
		logic [7:0] loopState;
		logic [NUM_REFS-1:0] refActive;
	} statusSrc_t;

	typedef struct packed {
		logic clearCommonIrq;
		logic clearCh0Irq;
		logic clearCh1Irq;
		logic [NUM_REFS-1:0] forceFault;
		logic [NUM_REFS-1:0] timeoutValidation;
	} ctrlOut_t;

	// Control function index to its code: 0..2 clears, 3..6 faults, 7..10 timeouts
	function automatic logic [6:0] ctrlCode(input int idx);
		if (idx < 3) begin
			return CODE_CLR_COMMON + 7'(idx);
		end else if (idx < 3 + NUM_REFS) begin
			return CODE_REF_FAULT + 7'(idx - 3);
		end
		return CODE_REF_ACTIVE + 7'(idx - 3 - NUM_REFS);
	endfunction : ctrlCode
endpackage : mfp_map_pkg

// ===== ctrl_term_combiner.sv
// Combines the pins assigned to one control function into a single term
`timescale 1ns/1ps
module ctrl_term_combiner
	import mfp_map_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [NUM_PINS-1:0] pinLevel,
	input wire logic [NUM_PINS-1:0] pinSel,
	input wire logic [NUM_PINS-1:0][1:0] boolCode,
	output logic term
);
	logic orUsed;
	logic orHit;
	logic andAll;
	logic lvl;

	always_comb begin
		orUsed = 1'b0;
		orHit = 1'b0;
		andAll = 1'b1;
		lvl = 1'b0;
		for (int i = 0; i < NUM_PINS; i++) begin
			lvl = pinLevel[i] ^ boolCode[i][BOOL_INV_BIT];
			if (pinSel[i]) begin
				if (boolCode[i][BOOL_OR_BIT]) begin
					orUsed = 1'b1;
					orHit = orHit | lvl;
				end else begin
					andAll = andAll & lvl;
				end
			end
		end
		// An empty OR group is neutral; no assigned pin at all gives no effect
		term = (|pinSel) & (orUsed ? orHit : 1'b1) & andAll;
	end

	unassigned_idle_a: assert property (@(posedge core_clk) disable iff (reset)
		(pinSel == '0) |-> !term)
		else $error("control term active with no pin assigned");
endmodule : ctrl_term_combiner

// ===== multipin_function_map_mid.sv
// Middle-range function decoder for multifunction pins, with its register port and interrupt
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module multipin_function_map_mid
	import mfp_map_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [DATA_W-1:0] regRdData,
	input wire logic [NUM_PINS-1:0] pinIn,
	output logic [NUM_PINS-1:0] pinOut,
	output logic [NUM_PINS-1:0] pinOe,
	input wire statusSrc_t statusSrc,
	output ctrlOut_t ctrlOut,
	output logic irq
);
	pinFunc_t funcReg_q [NUM_PINS];
	pinFunc_t funcReg_d [NUM_PINS];
	logic [NUM_PINS-1:0][1:0] boolCode_q;
	logic [NUM_PINS-1:0][1:0] boolCode_d;
	logic [7:0] irqMask_q;
	logic [7:0] irqMask_d;
	logic [7:0] irqStatus_q;
	logic [7:0] irqStatus_d;
	logic [DATA_W-1:0] rdData_q;
	logic [DATA_W-1:0] rdData_d;
	logic [NUM_PINS-1:0] pinOut_q;
	logic [NUM_PINS-1:0] pinOut_d;
	ctrlOut_t ctrl_q;
	ctrlOut_t ctrl_d;
	logic [NUM_EV-1:0] events;
	logic codeReject;
	logic [NUM_CTRL-1:0] ctrlTerm;
	logic [NUM_CTRL-1:0][NUM_PINS-1:0] ctrlSel;
	logic [NUM_CTRL-1:0] ctrlTermPrev_q;
	logic [NUM_CTRL-1:0] ctrlTermPrev_d;

	// Status source for one code; anything not decoded here stays low
	function automatic logic statusBit(input logic [6:0] code, input statusSrc_t s);
		logic r;
		r = 1'b0;
		case (code)
			CODE_CLR_COMMON: r = |s.commonIrq;
			CODE_CLR_CH0: r = |s.ch0Irq;
			CODE_CLR_CH1: r = |s.ch1Irq;
			CODE_DIV_RESYNC: r = s.divResyncA[DIV_RESYNC_LO_BIT];
			CODE_DIV_RESYNC + 7'h01: r = s.divResyncA[DIV_RESYNC_HI_BIT];
			CODE_DIV_RESYNC + 7'h02: r = s.divResyncB[DIV_RESYNC_LO_BIT];
			CODE_DIV_RESYNC + 7'h03: r = s.divResyncB[DIV_RESYNC_HI_BIT];
			CODE_REF_FAULT: r = s.refStat[0][REF_FAULT_BIT];
			CODE_REF_FAULT + 7'h01: r = s.refStat[1][REF_FAULT_BIT];
			CODE_REF_FAULT + 7'h02: r = s.refStat[2][REF_FAULT_BIT];
			CODE_REF_FAULT + 7'h03: r = s.refStat[3][REF_FAULT_BIT];
			CODE_REF_VALID: r = s.refStat[0][REF_VALID_BIT];
			CODE_REF_VALID + 7'h01: r = s.refStat[1][REF_VALID_BIT];
			CODE_REF_VALID + 7'h02: r = s.refStat[2][REF_VALID_BIT];
			CODE_REF_VALID + 7'h03: r = s.refStat[3][REF_VALID_BIT];
			CODE_REF_ACTIVE: r = s.refActive[0];
			CODE_REF_ACTIVE + 7'h01: r = s.refActive[1];
			CODE_REF_ACTIVE + 7'h02: r = s.refActive[2];
			CODE_REF_ACTIVE + 7'h03: r = s.refActive[3];
			CODE_LOOP_LOCK: r = s.loopLock[LOOP_LOCK_FIRST_BIT];
			CODE_LOOP_LOCK + 7'h01: r = s.loopLock[LOOP_LOCK_FIRST_BIT + 1];
			CODE_LOOP_LOCK + 7'h02: r = s.loopLock[LOOP_LOCK_FIRST_BIT + 2];
			CODE_LOOP_LOCK + 7'h03: r = s.loopLock[LOOP_LOCK_FIRST_BIT + 3];
			CODE_LOOP_ACTIVE: r = |s.loopActive[LOOP_ACTIVE_TOP_BIT:0];
			CODE_LOOP_STATE: r = s.loopState[LOOP_STATE_FIRST_BIT];
			CODE_LOOP_STATE + 7'h01: r = s.loopState[LOOP_STATE_FIRST_BIT + 1];
			CODE_LOOP_STATE + 7'h02: r = s.loopState[LOOP_STATE_FIRST_BIT + 2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : statusBit

	// True when a control write picks a code in range that carries no control function
	function automatic logic isDeadCtrl(input logic [DATA_W-1:0] w);
		logic hit;
		hit = 1'b0;
		for (int f = 0; f < NUM_CTRL; f++) begin
			if (w[6:0] == ctrlCode(f)) begin
				hit = 1'b1;
			end
		end
		return !w[7] && w[6:0] >= CODE_RANGE_LO && w[6:0] <= CODE_RANGE_HI && !hit;
	endfunction : isDeadCtrl

	// Register file
	always_comb begin
		codeReject = 1'b0;
		boolCode_d = boolCode_q;
		irqMask_d = irqMask_q;
		for (int i = 0; i < NUM_PINS; i++) begin
			funcReg_d[i] = funcReg_q[i];
			if (regWrStb && regAddr == ADDR_FUNC_BASE + ADDR_W'(i)) begin
				funcReg_d[i] = pinFunc_t'(regWrData);
				codeReject = isDeadCtrl(regWrData);
			end
			// Modulo keeps the unrolled select inside the byte for every pin
			if (regWrStb && regAddr == ADDR_BOOL_LO && i < BOOL_LO_PINS) begin
				boolCode_d[i] = regWrData[2*(i % BOOL_LO_PINS) +: 2];
			end
			if (regWrStb && regAddr == ADDR_BOOL_HI && i >= BOOL_LO_PINS) begin
				boolCode_d[i] = regWrData[2*(i % BOOL_LO_PINS) +: 2];
			end
		end
		if (regWrStb && regAddr == ADDR_IRQ_MASK) begin
			irqMask_d = regWrData;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				funcReg_q[i] <= pinFunc_t'(FUNC_RESET);
				boolCode_q[i] <= BOOL_RESET;
			end
			irqMask_q <= IRQ_MASK_RESET;
		end else begin
			funcReg_q <= funcReg_d;
			boolCode_q <= boolCode_d;
			irqMask_q <= irqMask_d;
		end
	end

	// Control pin selection, one combiner per control function
	always_comb begin
		for (int f = 0; f < NUM_CTRL; f++) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				ctrlSel[f][i] = !funcReg_q[i].outEn && funcReg_q[i].code == ctrlCode(f);
			end
		end
	end

	for (genvar f = 0; f < NUM_CTRL; f++) begin : gCtrl
		ctrl_term_combiner uCombiner (
			.core_clk(core_clk),
			.reset(reset),
			.pinLevel(pinIn),
			.pinSel(ctrlSel[f]),
			.boolCode(boolCode_q),
			.term(ctrlTerm[f])
		);
	end

	// Control proxies and status pins, registered so the outside sees clean levels
	always_comb begin
		ctrl_d.clearCommonIrq = ctrlTerm[0];
		ctrl_d.clearCh0Irq = ctrlTerm[1];
		ctrl_d.clearCh1Irq = ctrlTerm[2];
		ctrlTermPrev_d = ctrlTerm;
		for (int r = 0; r < NUM_REFS; r++) begin
			ctrl_d.forceFault[r] = ctrlTerm[3 + r];
			// A timeout on a healthy reference would skip its validation, so it is dropped
			ctrl_d.timeoutValidation[r] = ctrlTerm[3 + NUM_REFS + r] && statusSrc.refStat[r][REF_FAULT_BIT];
		end
		for (int i = 0; i < NUM_PINS; i++) begin
			pinOut_d[i] = funcReg_q[i].outEn && statusBit(funcReg_q[i].code, statusSrc);
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= '0;
			pinOut_q <= '0;
			ctrlTermPrev_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			pinOut_q <= pinOut_d;
			ctrlTermPrev_q <= ctrlTermPrev_d;
		end
	end

	assign ctrlOut = ctrl_q;
	assign pinOut = pinOut_q;
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pinOe[i] = funcReg_q[i].outEn;
		end
	end

	// Interrupt events on control rising edges and rejected codes
	always_comb begin
		events = '0;
		events[EV_IRQ_CLEAR] = |(ctrlTerm[2:0] & ~ctrlTermPrev_q[2:0]);
		events[EV_FAULT_FORCE] = |(ctrlTerm[3 +: NUM_REFS] & ~ctrlTermPrev_q[3 +: NUM_REFS]);
		events[EV_VALID_TIMEOUT] = |(ctrl_d.timeoutValidation & ~ctrl_q.timeoutValidation);
		events[EV_CODE_REJECT] = codeReject;
	end

	// Read data; a status read clears, but an event in the same cycle survives
	always_comb begin
		irqStatus_d = irqStatus_q;
		rdData_d = '0;
		if (regRdStb) begin
			if (regAddr == ADDR_IRQ_STATUS) begin
				rdData_d = irqStatus_q;
				irqStatus_d = '0;
			end else if (regAddr == ADDR_IRQ_MASK) begin
				rdData_d = irqMask_q;
			end else if (regAddr == ADDR_PIN_LEVEL) begin
				rdData_d = {1'b0, pinIn};
			end else if (regAddr == ADDR_CTRL_STATE) begin
				rdData_d = {1'b0, ctrl_q.clearCh1Irq, ctrl_q.clearCh0Irq, ctrl_q.clearCommonIrq, ctrl_q.forceFault};
			end else if (regAddr == ADDR_BOOL_LO) begin
				rdData_d = {boolCode_q[3], boolCode_q[2], boolCode_q[1], boolCode_q[0]};
			end else if (regAddr == ADDR_BOOL_HI) begin
				rdData_d = {2'h0, boolCode_q[6], boolCode_q[5], boolCode_q[4]};
			end else begin
				for (int i = 0; i < NUM_PINS; i++) begin
					if (regAddr == ADDR_FUNC_BASE + ADDR_W'(i)) begin
						rdData_d = funcReg_q[i];
					end
				end
			end
		end
		irqStatus_d[NUM_EV-1:0] = irqStatus_d[NUM_EV-1:0] | events;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irqStatus_q <= '0;
			rdData_q <= '0;
		end else begin
			irqStatus_q <= irqStatus_d;
			rdData_q <= rdData_d;
		end
	end

	assign regRdData = rdData_q;
	assign irq = |(irqStatus_q & irqMask_q);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence pin0Status(logic [6:0] c);
		funcReg_q[0].outEn && funcReg_q[0].code == c;
	endsequence

	sequence funcWrite0;
		regWrStb && regAddr == ADDR_FUNC_BASE;
	endsequence

	// Pin 0 alone on control function f, taken as is; shared groups are left to the combiner
	sequence soleCtrl0(int f);
		ctrlSel[f] == 7'h01 && boolCode_q[0] == 2'h0 && pinIn[0];
	endsequence

	sequence statusRead;
		regRdStb && regAddr == ADDR_IRQ_STATUS;
	endsequence

	pin_role_a: assert property (funcWrite0 |=> pinOe[0] == $past(regWrData[7]))
		else $error("pin output enable does not follow its function register");
	clear_common_a: assert property (ctrlOut.clearCommonIrq |-> $past(|ctrlSel[0]))
		else $error("common clear asserted with no pin assigned");
	common_status_a: assert property (pin0Status(CODE_CLR_COMMON) |=> pinOut[0] == $past(|statusSrc.commonIrq))
		else $error("common event status wrong");
	ch0_status_a: assert property (pin0Status(CODE_CLR_CH0) |=> pinOut[0] == $past(|statusSrc.ch0Irq))
		else $error("channel zero event status wrong");
	resync_status_a: assert property (pin0Status(CODE_DIV_RESYNC) |=> pinOut[0] == $past(statusSrc.divResyncA[3]))
		else $error("divider resync status wrong");
	fault_force_a: assert property (ctrlOut.forceFault[2] |-> $past(|ctrlSel[5]))
		else $error("fault forced with no pin assigned");
	timeout_gate_a: assert property (ctrlOut.timeoutValidation[0] |-> $past(statusSrc.refStat[0][3]))
		else $error("validation timeout on a healthy reference");
	lock_status_a: assert property (pin0Status(CODE_LOOP_LOCK) |=> pinOut[0] == $past(statusSrc.loopLock[1]))
		else $error("loop lock status wrong");
	active_status_a: assert property (pin0Status(CODE_LOOP_ACTIVE) |=> pinOut[0] == $past(|statusSrc.loopActive[5:0]))
		else $error("loop active status wrong");
	unused_low_a: assert property (pin0Status(CODE_UNUSED_2C) |=> !pinOut[0])
		else $error("unassigned status code drives high");
	// A set bit survives every cycle that is not a status read
	event_sticky_a: assert property (irqStatus_q[EV_FAULT_FORCE] && !(regRdStb && regAddr == ADDR_IRQ_STATUS)
		|=> irqStatus_q[EV_FAULT_FORCE])
		else $error("interrupt status bit lost without a read");
	read_data_a: assert property (statusRead |=> regRdData == $past(irqStatus_q))
		else $error("status read data wrong");
	sole_clear_a: assert property (soleCtrl0(0) |=> ctrlOut.clearCommonIrq)
		else $error("common clear not taken from its pin");
	ch0_clear_a: assert property (soleCtrl0(1) |=> ctrlOut.clearCh0Irq)
		else $error("channel zero clear not taken from its pin");
	ch1_clear_a: assert property (soleCtrl0(2) |=> ctrlOut.clearCh1Irq)
		else $error("channel one clear not taken from its pin");
	sole_fault_a: assert property (soleCtrl0(3) |=> ctrlOut.forceFault[0])
		else $error("fault force not taken from its pin");
	timeout_pass_a: assert property (soleCtrl0(7) ##0 statusSrc.refStat[0][3] |=> ctrlOut.timeoutValidation[0])
		else $error("validation timeout dropped on a faulted reference");
	fault_status_a: assert property (pin0Status(CODE_REF_FAULT) |=> pinOut[0] == $past(statusSrc.refStat[0][3]))
		else $error("reference faulted status wrong");
	valid_status_a: assert property (pin0Status(CODE_REF_VALID) |=> pinOut[0] == $past(statusSrc.refStat[0][4]))
		else $error("reference valid status wrong");
	active_ref_a: assert property (pin0Status(CODE_REF_ACTIVE) |=> pinOut[0] == $past(statusSrc.refActive[0]))
		else $error("reference active status wrong");
	state_status_a: assert property (pin0Status(CODE_LOOP_STATE) |=> pinOut[0] == $past(statusSrc.loopState[0]))
		else $error("loop state status wrong");
	resync_b_a: assert property (pin0Status(CODE_DIV_RESYNC + 7'h03) |=> pinOut[0] == $past(statusSrc.divResyncB[7]))
		else $error("last divider resync status wrong");
	lock_cal_a: assert property (pin0Status(CODE_LOOP_LOCK + 7'h03) |=> pinOut[0] == $past(statusSrc.loopLock[4]))
		else $error("calibration busy status wrong");
	ctrl_pin_low_a: assert property (!funcReg_q[0].outEn |=> !pinOut[0])
		else $error("control pin shows a status level");
endmodule : multipin_function_map_mid

// ===== mfp_board_model.sv
// Board-side logic on the multifunction pins: drives control levels and reads back status
`timescale 1ns/1ps
module mfp_board_model
	import mfp_map_pkg::*;
(
	input wire logic [NUM_PINS-1:0] drvLevel,
	input wire logic [NUM_PINS-1:0] pinOut,
	input wire logic [NUM_PINS-1:0] pinOe,
	output logic [NUM_PINS-1:0] pinIn
);
	// Board drives only where the device has released the pin, so no pin has two drivers
	assign pinIn = (pinOe & pinOut) | (~pinOe & drvLevel);
endmodule : mfp_board_model

// ===== tb_multipin_function_map_mid.sv
// Self-checking bench for the middle-range multifunction pin decoder
`timescale 1ns/1ps
module tb_multipin_function_map_mid
	import mfp_map_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic [DATA_W-1:0] regRdData;
	logic [NUM_PINS-1:0] pinIn;
	logic [NUM_PINS-1:0] pinOut;
	logic [NUM_PINS-1:0] pinOe;
	logic [NUM_PINS-1:0] drvLevel = '0;
	statusSrc_t statusSrc = '0;
	ctrlOut_t ctrlOut;
	logic irq;
	int failCount = 0;
	int numChecks = 0;

	always #12.5 core_clk = ~core_clk;

	multipin_function_map_mid multipin_function_map_mid_inst (.core_clk(core_clk), .reset(reset),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .statusSrc(statusSrc),
		.ctrlOut(ctrlOut), .irq(irq));
	mfp_board_model mfp_board_model_inst (.drvLevel(drvLevel), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		numChecks++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
	endtask : rd

	// Settle: let the register and the output stage each take one edge
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	function automatic logic expStat(input logic [6:0] c, input statusSrc_t s);
		case (c) inside
			7'h11: return |s.commonIrq;
			7'h12: return |s.ch0Irq;
			7'h13: return |s.ch1Irq;
			7'h1C: return s.divResyncA[3];
			7'h1D: return s.divResyncA[7];
			7'h1E: return s.divResyncB[3];
			7'h1F: return s.divResyncB[7];
			[7'h20:7'h23]: return s.refStat[c - 7'h20][3];
			[7'h24:7'h27]: return s.refStat[c - 7'h24][4];
			[7'h28:7'h2B]: return s.refActive[c - 7'h28];
			[7'h30:7'h33]: return s.loopLock[c - 7'h2F];
			7'h34: return |s.loopActive[5:0];
			[7'h35:7'h37]: return s.loopState[c - 7'h35];
			default: return 1'b0;
		endcase
	endfunction : expStat

	// Bit order of the control carrier: clears at 10..8, faults at 7..4, timeouts at 3..0
	function automatic logic [10:0] expCtrl(input logic [6:0] c);
		if (c >= 7'h11 && c <= 7'h13) return 11'h400 >> (c - 7'h11);
		if (c >= 7'h20 && c <= 7'h23) return 11'h010 << (c - 7'h20);
		if (c >= 7'h28 && c <= 7'h2B) return 11'h001 << (c - 7'h28);
		return 11'h000;
	endfunction : expCtrl

	task automatic testStatus();
		statusSrc_t pat;
		for (int p = 0; p < 5; p++) begin
			pat = (p == 0) ? '0 : (p == 1) ? '1 : (p == 2) ? {25{4'hA}} : (p == 3) ? {25{4'h5}} :
				100'h0F1E2D3C4B5A69788796A5B4C;
			@(posedge core_clk) statusSrc <= pat;
			for (int k = 'h11; k <= 'h37; k++) begin
				wr(ADDR_FUNC_BASE, {1'b1, 7'(k)});
				settle();
				chk(16'(pinOe[0]), 16'h0001);
				chk(16'(pinOut[0]), 16'(expStat(7'(k), pat)));
			end
		end
		// Pin 6 as status beside pin 0: each pin carries its own code
		wr(ADDR_FUNC_BASE + 8'h06, {1'b1, CODE_LOOP_ACTIVE});
		settle();
		chk(16'(pinOe), 16'h0041);
		chk(16'(pinOut), 16'({expStat(CODE_LOOP_ACTIVE, pat), 5'h00, expStat(7'h37, pat)}));
		wr(ADDR_FUNC_BASE + 8'h06, FUNC_RESET);
		$display("test status done");
	endtask : testStatus

	task automatic testCtrl();
		@(posedge core_clk) statusSrc <= '1;
		for (int k = 'h11; k <= 'h37; k++) begin
			wr(ADDR_FUNC_BASE, {1'b0, 7'(k)});
			@(posedge core_clk) drvLevel <= 7'h01;
			settle();
			chk(16'(ctrlOut), 16'(expCtrl(7'(k))));
			@(posedge core_clk) drvLevel <= 7'h00;
			settle();
			chk(16'(ctrlOut), 16'h0000);
		end
		// Timeout must be held off while the reference is not faulted
		wr(ADDR_FUNC_BASE, {1'b0, CODE_REF_ACTIVE});
		@(posedge core_clk) statusSrc <= '0;
		drvLevel <= 7'h01;
		settle();
		chk(16'(ctrlOut), 16'h0000);
		@(posedge core_clk) statusSrc <= '1;
		settle();
		chk(16'(ctrlOut), 16'h0001);
		@(posedge core_clk) drvLevel <= 7'h00;
		$display("test control done");
	endtask : testCtrl

	task automatic testBool();
		logic [3:0] v;
		// Pin0 AND, pin1 NOT OR, pin2 NOT AND, pin3 OR
		wr(ADDR_BOOL_LO, 8'h9C);
		for (int i = 0; i < 4; i++) wr(ADDR_FUNC_BASE + 8'(i), {1'b0, CODE_REF_FAULT});
		for (int k = 0; k < 16; k++) begin
			v = 4'(k);
			@(posedge core_clk) drvLevel <= {3'b000, v};
			settle();
			chk(16'(ctrlOut.forceFault[0]), 16'((!v[1] || v[3]) && v[0] && !v[2]));
		end
		@(posedge core_clk) drvLevel <= 7'h00;
		wr(ADDR_BOOL_LO, 8'(BOOL_RESET));
		for (int i = 1; i < 4; i++) wr(ADDR_FUNC_BASE + 8'(i), FUNC_RESET);
		$display("test boolean done");
	endtask : testBool

	task automatic testIrq();
		logic [7:0] d;
		wr(ADDR_FUNC_BASE, {1'b0, CODE_REF_FAULT});
		wr(ADDR_IRQ_MASK, 8'h00);
		rd(ADDR_IRQ_STATUS, d);
		rd(ADDR_IRQ_STATUS, d);
		chk(16'(d), 16'h0000);
		@(posedge core_clk) drvLevel <= 7'h01;
		settle();
		@(posedge core_clk);
		#1;
		chk(16'(irq), 16'h0000);
		rd(ADDR_IRQ_STATUS, d);
		chk(16'(d), 16'h0002);
		rd(ADDR_IRQ_STATUS, d);
		chk(16'(d), 16'h0000);
		@(posedge core_clk) drvLevel <= 7'h00;
		wr(ADDR_IRQ_MASK, 8'h02);
		@(posedge core_clk) drvLevel <= 7'h01;
		settle();
		@(posedge core_clk);
		#1;
		chk(16'(irq), 16'h0001);
		rd(ADDR_IRQ_STATUS, d);
		chk(16'(d), 16'h0002);
		settle();
		chk(16'(irq), 16'h0000);
		rd(ADDR_PIN_LEVEL, d);
		chk(16'(d), 16'h0001);
		wr(8'h40, 8'hFF);
		rd(8'h40, d);
		chk(16'(d), 16'h0000);
		rd(ADDR_IRQ_MASK, d);
		chk(16'(d), 16'h0002);
		// A control code with no function: flagged, and its pin moves nothing
		wr(ADDR_FUNC_BASE + 8'h01, {1'b0, CODE_UNUSED_2C});
		@(posedge core_clk) drvLevel <= 7'h03;
		settle();
		chk(16'(ctrlOut), 16'h0010);
		rd(ADDR_IRQ_STATUS, d);
		chk(16'(d), 16'h0008);
		$display("test interrupt done");
	endtask : testIrq

	task automatic tallyAndFinish();
		$display("checks=%0d mismatches=%0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tallyAndFinish

	initial begin
		logic [7:0] d;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		rd(ADDR_IRQ_MASK, d);
		chk(16'(d), 16'(IRQ_MASK_RESET));
		chk(16'(pinOe), 16'h0000);
		chk(16'(ctrlOut), 16'h0000);
		$display("test reset done");
		testStatus();
		testCtrl();
		testBool();
		testIrq();
		tallyAndFinish();
	end

	// A hang counts as a mismatch and closes the run through the same report
	initial begin
		repeat (90000) @(posedge core_clk);
		failCount++;
		tallyAndFinish();
	end
endmodule : tb_multipin_function_map_mid
